// ### rtl/core_regs_map.vh
`ifndef CORE_REGS_MAP_VH
`define CORE_REGS_MAP_VH
// Special function register addresses.
`define STATUS_WORD_ADDR   8'hD0
`define MAIN_OPERAND_ADDR  8'hE0
`define SCRATCH_B_ADDR     8'hF0
// Status word field positions.
`define CARRY_BIT          7
`define NIBBLE_CARRY_BIT   6
`define USER_FLAG_ZERO_BIT 5
`define BANK_SEL_HI        4
`define BANK_SEL_LO        3
`define OVERFLOW_BIT       2
`define USER_FLAG_ONE_BIT  1
`define PARITY_BIT         0
// Reset values.
`define STATUS_WORD_RESET  8'h00
`define MAIN_OPERAND_RESET 8'h00
`define SCRATCH_B_RESET    8'h00
`define WORK_REG_RESET     8'h00
// Working register window in DATA space.
`define WORK_REG_TOP       8'h1F
`endif

// ### rtl/cpu_core_register_set.v
// How it works
// - Four banks of eight bytes occupy DATA addresses 0x00 to 0x1F.
// - Status bits 4:3 select which bank bank relative accesses use; DATA port accesses ignore them.
// - Bit 7 set on add carry or subtract borrow, else cleared by arithmetic.
// - Bit 6 set on carry into or borrow from high nibble, else cleared.
// - Bit 2 set on arithmetic or multiply/divide overflow, independent of carry, else cleared.
// - Bit 0 shows odd parity of the main operand register.
// - Bits 5 and 1 are user flags, never changed by hardware.
// - Status word sits at special address 0xD0, bit addressable, resets zero.
// - Main operand register at 0xE0 resets to zero, used by most instructions.
// - B supplies second multiply/divide operand, otherwise plain scratch byte.
// - B register sits at special address 0xF0, resets to zero.
`timescale 1ns/10ps
`default_nettype none
`include "core_regs_map.vh"
module cpu_core_register_set
#(
    parameter WORK_REG_COUNT = 32
)
(
    // Clock and reset.
    input  wire       core_clk_in,
    input  wire       rst_n_in,
    // Special function space port, byte or bit write.
    input  wire       spc_wr_in,
    input  wire       spc_bit_wr_in,
    input  wire [2:0] spc_bit_sel_in,
    input  wire [7:0] spc_addr_in,
    input  wire [7:0] spc_wdata_in,
    output reg  [7:0] spc_rdata_out,
    // Working register port in DATA space.
    input  wire       data_wr_in,
    input  wire [7:0] data_addr_in,
    input  wire [7:0] data_wdata_in,
    output reg  [7:0] data_rdata_out,
    // Bank relative working register port.
    input  wire       bank_wr_in,
    input  wire [2:0] bank_reg_in,
    input  wire [7:0] bank_wdata_in,
    output reg  [7:0] bank_rdata_out,
    // Result write from the execution unit.
    input  wire       opnd_load_in,
    input  wire [7:0] opnd_result_in,
    input  wire       arith_done_in,
    input  wire       carry_in,
    input  wire       nibble_carry_in,
    input  wire       overflow_in,
    // Operands and state for the execution unit.
    output reg  [7:0] main_operand_out,
    output reg  [7:0] second_operand_out,
    output reg  [7:0] program_status_word_out,
    output reg  [1:0] bank_select_out
);

    ////////////////////////////////////////////////////////////////////////
    // Storage.
    reg  [7:0] bank_working_regs [0:WORK_REG_COUNT-1];
    reg  [7:0] status_word_reg;
    reg  [7:0] arith_operand_reg;
    reg  [7:0] scratch_b_reg;

    // Next values.
    reg  [7:0] next_opnd;
    reg  [7:0] next_status;
    reg  [7:0] next_b;
    reg  [7:0] next_spc_rdata;
    reg  [7:0] next_data_rdata;
    reg  [7:0] next_bank_rdata;

    // Decoded requests.
    wire       opnd_byte_hit;
    wire       opnd_bit_hit;
    wire       status_byte_hit;
    wire       status_bit_hit;
    wire       b_byte_hit;
    wire       b_bit_hit;
    wire       data_hit;
    wire       data_write;
    wire       bank_write;
    wire [4:0] data_index;
    wire [4:0] bank_index;
    integer    i;

    ////////////////////////////////////////////////////////////////////////
    // Decides whether a request addresses one special register.
    function addr_match;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_match = (addr == target);
        end
    endfunction

    // Applies a byte write or a single bit write to a register value.
    function [7:0] apply_write;
        input [7:0] old;
        input       byte_wr;
        input       bit_wr;
        input [2:0] sel;
        input [7:0] wdata;
        begin
            apply_write = old;
            if (byte_wr)
                apply_write = wdata;
            else if (bit_wr)
                apply_write[sel] = wdata[0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address decoding.
    assign opnd_byte_hit   = spc_wr_in && addr_match(spc_addr_in, `MAIN_OPERAND_ADDR);
    assign opnd_bit_hit    = spc_bit_wr_in && addr_match(spc_addr_in, `MAIN_OPERAND_ADDR);
    assign status_byte_hit = spc_wr_in && addr_match(spc_addr_in, `STATUS_WORD_ADDR);
    assign status_bit_hit  = spc_bit_wr_in && addr_match(spc_addr_in, `STATUS_WORD_ADDR);
    assign b_byte_hit      = spc_wr_in && addr_match(spc_addr_in, `SCRATCH_B_ADDR);
    assign b_bit_hit       = spc_bit_wr_in && addr_match(spc_addr_in, `SCRATCH_B_ADDR);

    // Working register window and bank relative index.
    assign data_hit   = (data_addr_in <= `WORK_REG_TOP);
    assign data_index = data_addr_in[4:0];
    assign bank_index = {status_word_reg[`BANK_SEL_HI:`BANK_SEL_LO], bank_reg_in};
    assign data_write = data_wr_in && data_hit;
    assign bank_write = bank_wr_in && !data_write;

    ////////////////////////////////////////////////////////////////////////
    // Main operand register; special space writes win over results.
    always @*
    begin
        next_opnd = arith_operand_reg;
        if (opnd_byte_hit || opnd_bit_hit)
            next_opnd = apply_write(arith_operand_reg, opnd_byte_hit, opnd_bit_hit,
                                    spc_bit_sel_in, spc_wdata_in);
        else if (opnd_load_in)
            next_opnd = opnd_result_in;
    end

    // Scratch byte, also the second operand of multiply and divide.
    always @*
    begin
        next_b = apply_write(scratch_b_reg, b_byte_hit, b_bit_hit,
                             spc_bit_sel_in, spc_wdata_in);
    end

    // Status word; software writes win over arithmetic flag updates.
    always @*
    begin
        next_status = status_word_reg;
        if (arith_done_in)
        begin
            next_status[`CARRY_BIT]        = carry_in;
            next_status[`NIBBLE_CARRY_BIT] = nibble_carry_in;
            next_status[`OVERFLOW_BIT]     = overflow_in;
        end
        next_status = apply_write(next_status, status_byte_hit, status_bit_hit,
                                  spc_bit_sel_in, spc_wdata_in);
        next_status[`PARITY_BIT] = ^next_opnd;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read paths, taken from the state before any same edge write.
    always @*
    begin
        case (spc_addr_in)
            `STATUS_WORD_ADDR:  next_spc_rdata = status_word_reg;
            `MAIN_OPERAND_ADDR: next_spc_rdata = arith_operand_reg;
            `SCRATCH_B_ADDR:    next_spc_rdata = scratch_b_reg;
            default:            next_spc_rdata = 8'h00;
        endcase
    end

    always @*
    begin
        next_data_rdata = 8'h00;
        if (data_hit)
            next_data_rdata = bank_working_regs[data_index];
        next_bank_rdata = bank_working_regs[bank_index];
    end

    ////////////////////////////////////////////////////////////////////////
    // Architectural registers.
    always @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            arith_operand_reg <= `MAIN_OPERAND_RESET;
            status_word_reg   <= `STATUS_WORD_RESET;
            scratch_b_reg     <= `SCRATCH_B_RESET;
        end
        else
        begin
            arith_operand_reg <= next_opnd;
            status_word_reg   <= next_status;
            scratch_b_reg     <= next_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output flip-flops.
    always @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            main_operand_out        <= `MAIN_OPERAND_RESET;
            second_operand_out      <= `SCRATCH_B_RESET;
            program_status_word_out <= `STATUS_WORD_RESET;
            bank_select_out         <= 2'h0;
            spc_rdata_out           <= 8'h00;
            data_rdata_out          <= 8'h00;
            bank_rdata_out          <= 8'h00;
        end
        else
        begin
            main_operand_out        <= next_opnd;
            second_operand_out      <= next_b;
            program_status_word_out <= next_status;
            bank_select_out         <= next_status[`BANK_SEL_HI:`BANK_SEL_LO];
            spc_rdata_out           <= next_spc_rdata;
            data_rdata_out          <= next_data_rdata;
            bank_rdata_out          <= next_bank_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Working registers; a DATA space write wins over a bank write.
    always @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            for (i = 0; i < WORK_REG_COUNT; i = i + 1)
                bank_working_regs[i] <= `WORK_REG_RESET;
        end
        else if (data_write)
        begin
            bank_working_regs[data_index] <= data_wdata_in;
        end
        else if (bank_write)
        begin
            bank_working_regs[bank_index] <= bank_wdata_in;
        end
    end

endmodule
`default_nettype wire

// ### test/core_regs_properties.sv
`timescale 1ns/10ps
`default_nettype none
module core_regs_properties
(
    // Watched ports.
    input wire logic       core_clk_in, rst_n_in, spc_wr_in, spc_bit_wr_in,
    input wire logic       arith_done_in, carry_in, nibble_carry_in, overflow_in,
    input wire logic [7:0] spc_addr_in, spc_wdata_in, spc_rdata_out, data_addr_in,
    input wire logic [7:0] data_rdata_out, main_operand_out, second_operand_out,
    input wire logic [7:0] program_status_word_out,
    input wire logic [1:0] bank_select_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire status_hit = (spc_wr_in || spc_bit_wr_in) && spc_addr_in == 8'hD0;
    sequence opnd_wr;
        spc_wr_in && spc_addr_in == 8'hE0;
    endsequence
    parity_follow_a: assert property (program_status_word_out[0] == ^main_operand_out)
        else $error("parity flag does not match operand");
    bank_field_a: assert property (bank_select_out == program_status_word_out[4:3])
        else $error("bank select differs from status bits");
    opnd_write_a: assert property (opnd_wr |=> main_operand_out == $past(spc_wdata_in))
        else $error("operand write lost");
    b_write_a: assert property (spc_wr_in && spc_addr_in == 8'hF0
        |=> second_operand_out == $past(spc_wdata_in)) else $error("scratch write lost");
    arith_flags_a: assert property (arith_done_in && !status_hit |=>
        program_status_word_out[7:6] == $past({carry_in, nibble_carry_in})
        && program_status_word_out[2] == $past(overflow_in))
        else $error("arithmetic flags wrong");
    user_flags_a: assert property (!status_hit |=> $stable(program_status_word_out[5])
        && $stable(program_status_word_out[1])) else $error("user flag changed");
    status_read_a: assert property (spc_addr_in == 8'hD0
        |=> spc_rdata_out == $past(program_status_word_out)) else $error("status read wrong");
    data_range_a: assert property (data_addr_in > 8'h1F |=> data_rdata_out == 8'h00)
        else $error("data read outside bank window");
endmodule
bind cpu_core_register_set core_regs_properties chk_i (.core_clk_in, .rst_n_in, .spc_wr_in,
    .spc_bit_wr_in, .arith_done_in, .carry_in, .nibble_carry_in, .overflow_in, .spc_addr_in,
    .spc_wdata_in, .spc_rdata_out, .data_addr_in, .data_rdata_out, .main_operand_out,
    .second_operand_out, .program_status_word_out, .bank_select_out);
`default_nettype wire

// ### test/cpu_core_register_set_test.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_core_register_set_test;
    logic       core_clk_in = 1'b0, rst_n_in = 1'b0, spc_wr_in = 1'b0, spc_bit_wr_in = 1'b0;
    logic       data_wr_in = 1'b0, bank_wr_in = 1'b0, opnd_load_in = 1'b0, arith_done_in = 1'b0;
    logic       carry_in = 1'b0, nibble_carry_in = 1'b0, overflow_in = 1'b0;
    logic [2:0] spc_bit_sel_in = 3'h0, bank_reg_in = 3'h0;
    logic [7:0] spc_addr_in = 8'h00, spc_wdata_in = 8'h00, data_addr_in = 8'h00;
    logic [7:0] data_wdata_in = 8'h00, bank_wdata_in = 8'h00, opnd_result_in = 8'h00;
    logic [7:0] spc_rdata_out, data_rdata_out, bank_rdata_out, main_operand_out;
    logic [7:0] second_operand_out, program_status_word_out;
    logic [1:0] bank_select_out;
    int         fail_count = 0, compares = 0;
    always #5 core_clk_in = ~core_clk_in;
    cpu_core_register_set uut (.core_clk_in, .rst_n_in, .spc_wr_in, .spc_bit_wr_in,
        .spc_bit_sel_in, .spc_addr_in, .spc_wdata_in, .spc_rdata_out, .data_wr_in, .data_addr_in,
        .data_wdata_in, .data_rdata_out, .bank_wr_in, .bank_reg_in, .bank_wdata_in,
        .bank_rdata_out, .opnd_load_in, .opnd_result_in, .arith_done_in, .carry_in,
        .nibble_carry_in, .overflow_in, .main_operand_out, .second_operand_out,
        .program_status_word_out, .bank_select_out);
    task chk(input logic [7:0] s, e);
        compares++;
        if (s !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task summarize;
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task sw(input logic [7:0] a, d);
        @(posedge core_clk_in);
        {spc_wr_in, spc_addr_in, spc_wdata_in} <= {1'b1, a, d};
        @(posedge core_clk_in);
        spc_wr_in <= 1'b0;
    endtask
    task bw(input logic [7:0] a, input logic [2:0] s, input logic [7:0] d);
        @(posedge core_clk_in);
        {spc_bit_wr_in, spc_addr_in, spc_bit_sel_in, spc_wdata_in} <= {1'b1, a, s, d};
        @(posedge core_clk_in);
        spc_bit_wr_in <= 1'b0;
    endtask
    task sr(input logic [7:0] a, e);
        @(posedge core_clk_in);
        spc_addr_in <= a;
        @(posedge core_clk_in);
        #1 chk(spc_rdata_out, e);
    endtask
    initial
    begin
        #20000 fail_count++;
        summarize();
    end
    initial
    begin
        repeat (2) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        #1 chk(program_status_word_out | main_operand_out | second_operand_out, 8'h00);
        sw(8'hE0, 8'h07);
        #1 chk(program_status_word_out, 8'h01);
        chk(main_operand_out, 8'h07);
        sr(8'hE0, 8'h07);
        @(posedge core_clk_in);
        {opnd_load_in, opnd_result_in} <= {1'b1, 8'h03};
        @(posedge core_clk_in);
        opnd_load_in <= 1'b0;
        #1 chk(program_status_word_out, 8'h00);
        sw(8'hF0, 8'hA5);
        sr(8'hF0, 8'hA5);
        chk(second_operand_out, 8'hA5);
        sr(8'hD1, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            sw(8'hD0, {3'b001, i[1:0], 3'b010});
            @(posedge core_clk_in);
            {bank_wr_in, bank_reg_in, bank_wdata_in} <= {1'b1, 3'h5, 8'h40 + 8'(i)};
            @(posedge core_clk_in);
            {bank_wr_in, data_addr_in} <= {1'b0, 8'(8 * i + 5)};
            @(posedge core_clk_in);
            #1 chk(data_rdata_out, 8'h40 + 8'(i));
            chk(bank_rdata_out, 8'h40 + 8'(i));
            chk({6'h00, bank_select_out}, {6'h00, i[1:0]});
        end
        @(posedge core_clk_in);
        {data_wr_in, data_addr_in, data_wdata_in} <= {1'b1, 8'h20, 8'hFF};
        @(posedge core_clk_in);
        data_wr_in <= 1'b0;
        @(posedge core_clk_in);
        #1 chk(data_rdata_out, 8'h00);
        for (int j = 0; j < 8; j++)
        begin
            @(posedge core_clk_in);
            {arith_done_in, carry_in, nibble_carry_in, overflow_in} <= {1'b1, j[2:0]};
            @(posedge core_clk_in);
            arith_done_in <= 1'b0;
            #1 chk(program_status_word_out, {j[2], j[1], 3'b111, j[0], 2'b10});
            chk({7'h00, program_status_word_out[6]}, {7'h00, j[1]});
            chk({7'h00, program_status_word_out[2]}, {7'h00, j[0]});
        end
        bw(8'hD0, 3'h5, 8'h00);
        sr(8'hD0, 8'hDE);
        bw(8'hE0, 3'h7, 8'h01);
        #1 chk(main_operand_out, 8'h83);
        chk(program_status_word_out, 8'hDF);
        bw(8'hF0, 3'h0, 8'h00);
        #1 chk(second_operand_out, 8'hA4);
        summarize();
    end
endmodule
`default_nettype wire
